/* File: hw/rssc_ctrl.sv */
// State report and command registers with transition sequencing
//
// Overview of operation
// - Read-only status at address 0x01, low five bits hold state code.
// - Basic state codes: power-on, busy rx/tx, rx-on, off, PLL-on, sleep.
// - Extended mode codes 0x11, 0x12, 0x16, 0x19; others reserved.
// - Unfinished transition reads as pending code 0x1F, except the return from busy transmit, which keeps its busy code.
// - Status register is not accessible while asleep.
// - Writing command field at address 0x02 starts a transition.
// - Rising edge on sleep/transmit pin can start certain transitions.
// - Bit 7 channel check finished, bit 6 result, bit 5 reserved.
// - Bits 7:5 of command register hold read-only transaction result.
// - Bits 4:0 of command register are read-write command field.
// - Receive to transmit settles within 16 us.
// - Transmit to receive settles within 32 us.
// - Signal strength refreshed every 2 us in receive states.
// - Random value refreshed every 1 us.
// - Channel check spans eight symbols, at most 180 us.
// - Energy detection typically 135 us, at most 180 us.
// - Off to PLL-on settles typically 80 us, at most 250 us; forced PLL-on from off takes the 1 us short count instead.
// - Channel switch PLL resettling typically 11 us, at most 100 us.
// - Command codes: nop, tx start, forced off/PLL, rx, off, PLL, ext.
`timescale 1ns/1ps
module rssc_ctrl
    import rssc_pkg::*;
#(
    parameter int CYC_PLL_INIT = T_PLL_INIT_TYP_US * CLOCK_MHZ,
    parameter int CYC_PLL_SW = T_PLL_SW_TYP_US * CLOCK_MHZ,
    parameter int CYC_MEAS = T_ED_TYP_US * CLOCK_MHZ
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sleep_transmit_pin,
    input wire logic extended_mode,
    input wire logic rx_frame_start,
    input wire logic frame_end,
    input wire logic [2:0] transaction_in,
    input wire logic transaction_valid,
    input wire logic channel_change,
    input wire logic channel_check_start,
    input wire logic channel_busy_in,
    output logic [4:0] state_code,
    output logic rssi_refresh,
    output logic random_refresh
);
    // Synchroniser and edge register for the sleep/transmit pin
    logic slp_meta_reg;
    logic slp_sync_reg;
    logic slp_prev_reg;
    logic [4:0] state_reg, state_next;
    logic [4:0] target_reg, target_next;
    logic [4:0] cmd_reg, cmd_next;
    logic [2:0] result_reg, result_next;
    logic chk_done_reg, chk_done_next;
    logic chk_result_reg, chk_result_next;
    logic chk_busy_reg, chk_busy_next;
    logic pend_reg, pend_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [CNT_W-1:0] rssi_cnt_reg, rssi_cnt_next;
    logic [CNT_W-1:0] rnd_cnt_reg, rnd_cnt_next;
    logic rssi_reg, rssi_next;
    logic rnd_reg, rnd_next;
    logic tmr_start;
    logic [CNT_W-1:0] tmr_load;
    logic tmr_busy;
    logic tmr_done;
    logic slp_rise;
    logic cmd_write;

    // Settling count for each transition type
    function automatic logic [CNT_W-1:0] settle_cycles(
        input rssc_settle_t kind
    );
        case (kind)
            RSSC_SETTLE_RX_TX: settle_cycles = CNT_W'(CYC_RX_TX);
            RSSC_SETTLE_TX_RX: settle_cycles = CNT_W'(CYC_TX_RX);
            RSSC_SETTLE_PLL_INIT: settle_cycles = CNT_W'(CYC_PLL_INIT);
            RSSC_SETTLE_PLL_SW: settle_cycles = CNT_W'(CYC_PLL_SW);
            RSSC_SETTLE_MEAS: settle_cycles = CNT_W'(CYC_MEAS);
            default: settle_cycles = CNT_W'(CYC_SHORT);
        endcase
    endfunction : settle_cycles

    // True for states in which the receiver runs
    function automatic logic is_rx_state(input logic [4:0] s);
        is_rx_state = (s == ST_RX_ON) || (s == ST_BUSY_RX) ||
            (s == ST_AUTOACK_RX_ON) || (s == ST_BUSY_AUTOACK_RX);
    endfunction : is_rx_state

    rssc_timer u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .start(tmr_start),
        .load(tmr_load),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Pin passes two flops before any edge logic sees it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slp_meta_reg <= 1'b0;
            slp_sync_reg <= 1'b0;
            slp_prev_reg <= 1'b0;
        end else begin
            slp_meta_reg <= sleep_transmit_pin;
            slp_sync_reg <= slp_meta_reg;
            slp_prev_reg <= slp_sync_reg;
        end
    end

    assign slp_rise = slp_sync_reg & ~slp_prev_reg;
    assign cmd_write = reg_wr && (reg_addr == ADDR_STATE_COMMAND)
        && (state_reg != ST_SLEEP);

    // State sequencing; the host keeps off while a transition is pending,
    // but forced commands still cut in so software can always recover
    always_comb begin
        state_next = state_reg;
        target_next = target_reg;
        cmd_next = cmd_reg;
        pend_next = pend_reg;
        result_next = result_reg;
        tmr_start = 1'b0;
        tmr_load = settle_cycles(RSSC_SETTLE_SHORT);
        if (cmd_write) begin
            cmd_next = reg_wdata[CODE_MSB:0];
        end
        if (transaction_valid) begin
            result_next = transaction_in;
        end
        if (pend_reg && tmr_done) begin
            state_next = target_reg;
            pend_next = 1'b0;
        end else if (!pend_reg && frame_end &&
                     (state_reg == ST_BUSY_TX ||
                      state_reg == ST_BUSY_RETRY_TX)) begin
            // Back from transmit frequency to receive frequency
            pend_next = 1'b1;
            target_next = (state_reg == ST_BUSY_TX) ? ST_PLL_ON
                : ST_RETRY_TX_ON;
            tmr_start = 1'b1;
            tmr_load = settle_cycles(RSSC_SETTLE_TX_RX);
        end else if (!pend_reg && frame_end &&
                     (state_reg == ST_BUSY_RX ||
                      state_reg == ST_BUSY_AUTOACK_RX)) begin
            state_next = (state_reg == ST_BUSY_RX) ? ST_RX_ON
                : ST_AUTOACK_RX_ON;
        end else if (!pend_reg && rx_frame_start &&
                     (state_reg == ST_RX_ON ||
                      state_reg == ST_AUTOACK_RX_ON)) begin
            state_next = (state_reg == ST_RX_ON) ? ST_BUSY_RX
                : ST_BUSY_AUTOACK_RX;
        end else if (!pend_reg && slp_rise &&
                     (state_reg == ST_PLL_ON ||
                      state_reg == ST_RETRY_TX_ON)) begin
            state_next = ST_TRANSITION_PENDING;
            target_next = (state_reg == ST_PLL_ON) ? ST_BUSY_TX
                : ST_BUSY_RETRY_TX;
            pend_next = 1'b1;
            tmr_start = 1'b1;
            tmr_load = settle_cycles(RSSC_SETTLE_RX_TX);
        end else if (cmd_write) begin
            case (reg_wdata[CODE_MSB:0])
                CMD_FORCED_OFF: begin
                    target_next = ST_TRANSCEIVER_OFF;
                    pend_next = 1'b1;
                    tmr_start = 1'b1;
                end
                CMD_FORCED_PLL_ON: begin
                    if (state_reg != ST_POWER_ON) begin
                        target_next = ST_PLL_ON;
                        pend_next = 1'b1;
                        tmr_start = 1'b1;
                    end
                end
                CMD_TX_START: begin
                    if (state_reg == ST_PLL_ON ||
                        state_reg == ST_RETRY_TX_ON) begin
                        target_next = (state_reg == ST_PLL_ON) ?
                            ST_BUSY_TX : ST_BUSY_RETRY_TX;
                        pend_next = 1'b1;
                        tmr_start = 1'b1;
                        tmr_load = settle_cycles(RSSC_SETTLE_RX_TX);
                    end
                end
                CMD_RX_ON, CMD_OFF, CMD_PLL_ON: begin
                    if (!pend_reg) begin
                        target_next = reg_wdata[CODE_MSB:0];
                        pend_next = 1'b1;
                        tmr_start = 1'b1;
                        if (state_reg == ST_TRANSCEIVER_OFF &&
                            reg_wdata[CODE_MSB:0] != CMD_OFF)
                            tmr_load = settle_cycles(RSSC_SETTLE_PLL_INIT);
                    end
                end
                CMD_AUTOACK_RX, CMD_RETRY_TX: begin
                    if (!pend_reg && extended_mode) begin
                        target_next = reg_wdata[CODE_MSB:0];
                        pend_next = 1'b1;
                        tmr_start = 1'b1;
                        if (state_reg == ST_TRANSCEIVER_OFF)
                            tmr_load = settle_cycles(RSSC_SETTLE_PLL_INIT);
                    end
                end
                default: begin
                end
            endcase
            if (tmr_start) begin
                state_next = ST_TRANSITION_PENDING;
            end
        end else if (!pend_reg && channel_change &&
                     state_reg != ST_TRANSCEIVER_OFF &&
                     state_reg != ST_SLEEP &&
                     state_reg != ST_POWER_ON) begin
            target_next = state_reg;
            state_next = ST_TRANSITION_PENDING;
            pend_next = 1'b1;
            tmr_start = 1'b1;
            tmr_load = settle_cycles(RSSC_SETTLE_PLL_SW);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_POWER_ON;
            target_reg <= ST_POWER_ON;
            cmd_reg <= CMD_RESET;
            result_reg <= RESULT_RESET;
            pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            target_reg <= target_next;
            cmd_reg <= cmd_next;
            result_reg <= result_next;
            pend_reg <= pend_next;
        end
    end

    // Channel check uses its own count so it overlaps state settling
    logic [CNT_W-1:0] chk_cnt_reg, chk_cnt_next;
    always_comb begin
        chk_done_next = chk_done_reg;
        chk_result_next = chk_result_reg;
        chk_busy_next = chk_busy_reg;
        chk_cnt_next = chk_cnt_reg;
        if (channel_check_start && is_rx_state(state_reg)) begin
            chk_busy_next = 1'b1;
            chk_done_next = 1'b0;
            chk_cnt_next = settle_cycles(RSSC_SETTLE_MEAS);
        end else if (chk_busy_reg) begin
            if (chk_cnt_reg <= CNT_W'(1)) begin
                chk_busy_next = 1'b0;
                chk_done_next = 1'b1;
                chk_result_next = ~channel_busy_in;
            end else begin
                chk_cnt_next = chk_cnt_reg - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            chk_done_reg <= 1'b0;
            chk_result_reg <= 1'b0;
            chk_busy_reg <= 1'b0;
            chk_cnt_reg <= '0;
        end else begin
            chk_done_reg <= chk_done_next;
            chk_result_reg <= chk_result_next;
            chk_busy_reg <= chk_busy_next;
            chk_cnt_reg <= chk_cnt_next;
        end
    end

    // Periodic refresh strobes for signal strength and random value
    always_comb begin
        rssi_cnt_next = rssi_cnt_reg + CNT_W'(1);
        rssi_next = 1'b0;
        rnd_cnt_next = rnd_cnt_reg + CNT_W'(1);
        rnd_next = 1'b0;
        if (!is_rx_state(state_reg)) begin
            rssi_cnt_next = '0;
        end else if (rssi_cnt_reg == CNT_W'(CYC_RSSI - 1)) begin
            rssi_cnt_next = '0;
            rssi_next = 1'b1;
        end
        if (rnd_cnt_reg == CNT_W'(CYC_RND - 1)) begin
            rnd_cnt_next = '0;
            rnd_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rssi_cnt_reg <= '0;
            rnd_cnt_reg <= '0;
            rssi_reg <= 1'b0;
            rnd_reg <= 1'b0;
        end else begin
            rssi_cnt_reg <= rssi_cnt_next;
            rnd_cnt_reg <= rnd_cnt_next;
            rssi_reg <= rssi_next;
            rnd_reg <= rnd_next;
        end
    end

    // Read port; unmapped addresses and sleep reads return zero
    always_comb begin
        rdata_next = 8'h00;
        rvalid_next = reg_rd;
        if (reg_rd && reg_addr == ADDR_STATE_REPORT &&
            state_reg != ST_SLEEP) begin
            rdata_next = {chk_done_reg, chk_result_reg, 1'b0,
                state_reg};
        end else if (reg_rd && reg_addr == ADDR_STATE_COMMAND &&
                     state_reg != ST_SLEEP) begin
            rdata_next = {result_reg, cmd_reg};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign state_code = state_reg;
    assign rssi_refresh = rssi_reg;
    assign random_refresh = rnd_reg;

    a_pending_code: assert property (@(posedge clock) disable iff (!arst_n)
        pend_reg |-> state_reg == ST_TRANSITION_PENDING || tmr_busy
            || tmr_done) else $error("pending without timer");
    a_done_moves: assert property (@(posedge clock) disable iff (!arst_n)
        (pend_reg && tmr_done) |=> state_reg == $past(target_reg))
        else $error("state not updated on completion");
    a_cmd_stored: assert property (@(posedge clock) disable iff (!arst_n)
        cmd_write |=> cmd_reg == $past(reg_wdata[4:0]))
        else $error("command field not stored");
    a_sleep_read: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_rd && state_reg == ST_SLEEP) |=> reg_rdata == 8'h00)
        else $error("read in sleep returned data");
    a_report_read: assert property (@(posedge clock) disable iff (!arst_n)
        (reg_rd && reg_addr == ADDR_STATE_REPORT && state_reg != ST_SLEEP)
        |=> reg_rdata[4:0] == $past(state_reg) && !reg_rdata[5])
        else $error("status read wrong");
    a_rnd_period: assert property (@(posedge clock) disable iff (!arst_n)
        rnd_reg |=> !rnd_reg [*8])
        else $error("random strobe too frequent");
    a_ext_gate: assert property (@(posedge clock) disable iff (!arst_n)
        (cmd_write && !extended_mode && !pend_reg &&
         reg_wdata[4:0] == CMD_AUTOACK_RX) |=> !pend_reg)
        else $error("extended command taken in basic mode");
    a_pin_start: assert property (@(posedge clock) disable iff (!arst_n)
        (slp_rise && !pend_reg && state_reg == ST_PLL_ON) |=>
        state_reg == ST_TRANSITION_PENDING && target_reg == ST_BUSY_TX)
        else $error("pin edge did not start transmit");
    a_result_load: assert property (@(posedge clock) disable iff (!arst_n)
        transaction_valid |=> result_reg == $past(transaction_in))
        else $error("transaction result not held");
endmodule : rssc_ctrl

/* File: hw/rssc_pkg.sv */
// Package for radio state/status control register bank
package rssc_pkg;
    // Register addresses
    localparam logic [5:0] ADDR_STATE_REPORT = 6'h01;
    localparam logic [5:0] ADDR_STATE_COMMAND = 6'h02;
    // Field positions
    localparam int CHK_DONE_BIT = 7;
    localparam int CHK_RESULT_BIT = 6;
    localparam int RESULT_LSB = 5;
    localparam int CODE_MSB = 4;
    // Reset values
    localparam logic [4:0] CMD_RESET = 5'h00;
    localparam logic [2:0] RESULT_RESET = 3'h0;
    // State codes
    localparam logic [4:0] ST_POWER_ON = 5'h00;
    localparam logic [4:0] ST_BUSY_RX = 5'h01;
    localparam logic [4:0] ST_BUSY_TX = 5'h02;
    localparam logic [4:0] ST_RX_ON = 5'h06;
    localparam logic [4:0] ST_TRANSCEIVER_OFF = 5'h08;
    localparam logic [4:0] ST_PLL_ON = 5'h09;
    localparam logic [4:0] ST_SLEEP = 5'h0F;
    localparam logic [4:0] ST_BUSY_AUTOACK_RX = 5'h11;
    localparam logic [4:0] ST_BUSY_RETRY_TX = 5'h12;
    localparam logic [4:0] ST_AUTOACK_RX_ON = 5'h16;
    localparam logic [4:0] ST_RETRY_TX_ON = 5'h19;
    localparam logic [4:0] ST_TRANSITION_PENDING = 5'h1F;
    // Command codes
    localparam logic [4:0] CMD_NOP = 5'h00;
    localparam logic [4:0] CMD_TX_START = 5'h02;
    localparam logic [4:0] CMD_FORCED_OFF = 5'h03;
    localparam logic [4:0] CMD_FORCED_PLL_ON = 5'h04;
    localparam logic [4:0] CMD_RX_ON = 5'h06;
    localparam logic [4:0] CMD_OFF = 5'h08;
    localparam logic [4:0] CMD_PLL_ON = 5'h09;
    localparam logic [4:0] CMD_AUTOACK_RX = 5'h16;
    localparam logic [4:0] CMD_RETRY_TX = 5'h19;
    // Timing, figures in microseconds except the clock in MHz and the cycle counts
    localparam int CLOCK_MHZ = 200;
    localparam int T_RX_TX_US = 16;
    localparam int T_TX_RX_US = 32;
    localparam int T_RSSI_US = 2;
    localparam int T_RND_US = 1;
    localparam int T_CCA_MAX_US = 180;
    localparam int T_ED_TYP_US = 135;
    localparam int T_PLL_INIT_TYP_US = 80;
    localparam int T_PLL_SW_TYP_US = 11;
    localparam int T_SHORT_US = 1;
    localparam int CYC_RX_TX = T_RX_TX_US * CLOCK_MHZ;
    localparam int CYC_TX_RX = T_TX_RX_US * CLOCK_MHZ;
    localparam int CYC_RSSI = T_RSSI_US * CLOCK_MHZ;
    localparam int CYC_RND = T_RND_US * CLOCK_MHZ;
    localparam int CYC_SHORT = T_SHORT_US * CLOCK_MHZ;
    localparam int CNT_W = 17;
    // Transition type selecting the settling time
    typedef enum logic [2:0] {
        RSSC_SETTLE_SHORT = 3'b000,
        RSSC_SETTLE_RX_TX = 3'b001,
        RSSC_SETTLE_TX_RX = 3'b010,
        RSSC_SETTLE_PLL_INIT = 3'b011,
        RSSC_SETTLE_PLL_SW = 3'b100,
        RSSC_SETTLE_MEAS = 3'b101
    } rssc_settle_t;
endpackage : rssc_pkg

/* File: hw/rssc_timer.sv */
// Down-counting settling timer with one-cycle done pulse
`timescale 1ns/1ps
module rssc_timer
    import rssc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;

    // Start reloads even when busy so a forced command restarts timing
    always_comb begin
        count_next = count_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start) begin
            count_next = load;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (count_reg <= CNT_W'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - CNT_W'(1);
            end
        end
    end

    // Register stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : rssc_timer

/* File: test/rssc_host_model.sv */
// Host register access model for the radio state bank
`timescale 1ns/1ps
module rssc_host_model (
    input wire logic clock,
    output logic [5:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle bus parks on changing junk so stale values never look valid
    initial begin
        reg_addr = 6'h3F;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'hA5;
    end

    // One write strobe, held over exactly one sampling edge
    task automatic write(input logic [5:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask : write

    // Read strobe, then the registered answer is caught within two cycles
    task automatic read(input logic [5:0] addr, output logic [7:0] data,
                        output logic ok);
        @(negedge clock);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~addr;
        ok = 1'b0;
        data = 8'h00;
        for (int i = 0; i < 2 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                data = reg_rdata;
            end else @(negedge clock);
        end
    endtask : read
endmodule : rssc_host_model

/* File: test/testbench.sv */
// Self-checking bench for the radio state and status registers
`timescale 1ns/1ps
module testbench;
    import rssc_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, rssi_refresh, random_refresh;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] state_code;
    logic stp = 1'b0, ext = 1'b0, rxs = 1'b0, fend = 1'b0, tval = 1'b0;
    logic chg = 1'b0, chk = 1'b0, cbusy = 1'b0;
    logic [2:0] tin = 3'h0;
    int n_mismatch = 0;
    int checks = 0;

    // Short PLL and measurement counts keep the run brief
    rssc_ctrl #(.CYC_PLL_INIT(20), .CYC_PLL_SW(20), .CYC_MEAS(20)) dut_u (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sleep_transmit_pin(stp), .extended_mode(ext),
        .rx_frame_start(rxs), .frame_end(fend), .transaction_in(tin),
        .transaction_valid(tval), .channel_change(chg),
        .channel_check_start(chk), .channel_busy_in(cbusy),
        .state_code(state_code), .rssi_refresh(rssi_refresh),
        .random_refresh(random_refresh));
    rssc_host_model host_u (
        .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    always #2.5 clock = ~clock;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic rd_check(input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.read(addr, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask : rd_check

    // Bounded wait for a state code; the bound is the settling limit
    task automatic wait_state(input logic [4:0] code, input int limit);
        int n;
        n = 0;
        while (state_code !== code && n < limit) begin
            @(negedge clock);
            n++;
        end
        check({3'h0, state_code}, {3'h0, code});
    endtask : wait_state

    // Command write; the host only issues it from a stable state
    task automatic cmd(input logic [4:0] c, input int lim,
                       input logic [4:0] s);
        host_u.write(ADDR_STATE_COMMAND, {3'h7, c});
        @(negedge clock);
        check({3'h0, state_code}, {3'h0, ST_TRANSITION_PENDING});
        wait_state(s, lim);
    endtask : cmd

    task automatic t_reset();
        rd_check(ADDR_STATE_REPORT, 8'h00);
        rd_check(ADDR_STATE_COMMAND, 8'h00);
        rd_check(6'h05, 8'h00);
    endtask : t_reset

    task automatic t_bring_up();
        cmd(CMD_OFF, 210, ST_TRANSCEIVER_OFF);
        cmd(CMD_PLL_ON, 30, ST_PLL_ON);
        rd_check(ADDR_STATE_COMMAND, {3'h0, CMD_PLL_ON});
        host_u.write(ADDR_STATE_REPORT, 8'hFF);
        rd_check(ADDR_STATE_REPORT, {3'h0, ST_PLL_ON});
        @(negedge clock);
        chg = 1'b1;
        @(negedge clock);
        chg = 1'b0;
        check({3'h0, state_code}, {3'h0, ST_TRANSITION_PENDING});
        wait_state(ST_PLL_ON, 30);
    endtask : t_bring_up

    // Pin edge starts a send; pin is held four cycles, though the synchroniser also catches a one-cycle pulse
    task automatic t_tx_pin();
        @(negedge clock);
        stp = 1'b1;
        repeat (4) @(negedge clock);
        stp = 1'b0;
        wait_state(ST_BUSY_TX, 3205);
        fend = 1'b1;
        @(negedge clock);
        fend = 1'b0;
        wait_state(ST_PLL_ON, 6405);
    endtask : t_tx_pin

    task automatic t_rx();
        int n;
        cmd(CMD_RX_ON, 210, ST_RX_ON);
        // The strobe still stands one negedge after it rises; skip past it
        @(posedge rssi_refresh);
        @(negedge clock);
        @(negedge clock);
        n = 1;
        while (rssi_refresh !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        check(8'(n / 4), 8'd100);
        @(posedge random_refresh);
        @(negedge clock);
        @(negedge clock);
        n = 1;
        while (random_refresh !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        check(8'(n), 8'd200);
        chk = 1'b1;
        @(negedge clock);
        chk = 1'b0;
        repeat (40) @(negedge clock);
        rd_check(ADDR_STATE_REPORT, {3'b110, ST_RX_ON});
        rxs = 1'b1;
        @(negedge clock);
        rxs = 1'b0;
        wait_state(ST_BUSY_RX, 5);
        fend = 1'b1;
        @(negedge clock);
        fend = 1'b0;
        wait_state(ST_RX_ON, 210);
    endtask : t_rx

    task automatic t_ext();
        // Extended command is refused while the mode is off
        host_u.write(ADDR_STATE_COMMAND, {3'h0, CMD_AUTOACK_RX});
        @(negedge clock);
        check({3'h0, state_code}, {3'h0, ST_RX_ON});
        ext = 1'b1;
        cmd(CMD_AUTOACK_RX, 210, ST_AUTOACK_RX_ON);
        rxs = 1'b1;
        @(negedge clock);
        rxs = 1'b0;
        wait_state(ST_BUSY_AUTOACK_RX, 5);
        tin = 3'h5;
        tval = 1'b1;
        @(negedge clock);
        tval = 1'b0;
        fend = 1'b1;
        @(negedge clock);
        fend = 1'b0;
        wait_state(ST_AUTOACK_RX_ON, 210);
        rd_check(ADDR_STATE_COMMAND, {3'h5, CMD_AUTOACK_RX});
        host_u.write(ADDR_STATE_COMMAND, {3'h0, CMD_FORCED_OFF});
        wait_state(ST_TRANSCEIVER_OFF, 210);
    endtask : t_ext

    initial begin
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        t_reset();
        t_bring_up();
        t_tx_pin();
        t_rx();
        t_ext();
        conclude();
    end

    // Watchdog well beyond the longest settling chain
    initial begin
        #150000;
        n_mismatch++;
        conclude();
    end
endmodule : testbench
